// ==== gfs_top.sv ====
// gfs_top.sv: receive framing monitor, link sequencer and avalon slave.
// assumes the group, squelch, delay and encryptor pins are asynchronous to mclk; group data is stable at
// the rising edge of the group bit clock.
//
// Our own choices: the address map and the Avalon-MM register port.
`include "gfs_defines.svh"
`default_nettype none
module gfs_top #(
  parameter logic [31:0] T_DELAY = 32'(`GFS_MS2CYC(`GFS_T_DELAY_MS)),
  parameter logic [31:0] T_TOUT = 32'(`GFS_MS2CYC(`GFS_T_TOUT_MS)),
  parameter logic [31:0] T_RETRY = 32'(`GFS_MS2CYC(`GFS_T_RETRY_MS)),
  parameter logic [31:0] T_WAIT = 32'(`GFS_US2CYC(`GFS_T_WAIT_US)),
  parameter logic [31:0] T_PULSE = 32'(`GFS_US2CYC(`GFS_T_PULSE_US))
) (
  input wire logic mclk, // system clock
  input wire logic reset, // sync reset, high
  input wire logic ce, // clock enable
  input wire gfs_pkg::gfs_avl_req_t avl_req, // avalon request
  output logic [31:0] avl_readdata, // avalon read data
  output logic avl_waitrequest, // avalon wait
  input wire logic gclk_pin, // group bit clock
  input wire logic rx_data_pin, // received group data
  input wire logic squelch_n_pin, // low forces in frame
  input wire logic delay_sw_pin, // 1 = half second delay on
  input wire logic link_encryptor_fitted_n, // 0 = encryptor fitted
  input wire logic link_encryptor_sync, // 1 = sync achieved
  output logic ds_data, // downstream data
  output logic err_pulse, // frame bit error
  output logic frame_ref, // frame reference
  output logic frame_pulse, // frame bit position
  output logic go_frame_n, // search command
  output logic rx_inframe, // receive side in frame
  output logic tx_inframe, // far end in frame
  output logic rx_data_en, // 0 = downstream ones
  output logic tx_data_en, // 0 = transmit zeros
  output logic pattern_sel, // 0 = ones, 1 = alternating
  output logic link_encryptor_resync, // resync pulse
  output logic frame_alarm_n // 0 = frame alarm
);
  import gfs_pkg::*;

  // -------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------
  logic [5:0] s1, s2;
  logic gprev;
  logic stb, d, sq_n, dly_on, fit, esync;

  // two flops per pin, plus a delayed copy of the bit clock
  always_ff @(posedge mclk) begin
    if (reset) begin
      s1 <= 6'h00;
      s2 <= 6'h00;
      gprev <= 1'b0;
    end else if (ce) begin
      s1 <= {link_encryptor_sync, link_encryptor_fitted_n, delay_sw_pin,
             squelch_n_pin, rx_data_pin, gclk_pin};
      s2 <= s1;
      gprev <= s2[0];
    end
  end

  assign stb = s2[0] & ~gprev; // rising bit clock edge
  assign d = s2[1];
  assign sq_n = s2[2];
  assign dly_on = s2[3];
  assign fit = ~s2[4];
  assign esync = s2[5] | ~fit; // no encryptor counts as in sync

  // -------------------------------------------------------------
  // framing monitor
  // -------------------------------------------------------------
  gfs_fstate_t fst, next_fst;
  logic [6:0] pos, next_pos, nfb, next_nfb, k;
  logic [2:0][6:0] corr, next_corr, cn;
  logic [2:0][5:0] tc, next_tc, tn;
  logic [4:0] tcnt, next_tcnt;
  logic [8:0] zc, next_zc;
  logic [9:0] zo, next_zo;
  logic [2:0] hit;
  logic ref_b, next_ref, ifr, next_ifr, fail1, next_fail1;
  logic txif, next_txif, zero, next_zero, locked;
  logic next_ds, next_err, next_fp, acq_ok, mnt_ok;

  assign locked = (fst != F_IDLE) && (fst != F_HUNT);
  assign k = nfb + 7'd1;
  assign hit = {d, d != ref_b, d == ref_b}; // ones, 0101, 1010

  // next state of the framer, zero detector and far end detector
  always_comb begin
    next_fst = fst;
    next_pos = pos;
    next_nfb = nfb;
    next_corr = corr;
    next_tc = tc;
    next_tcnt = tcnt;
    next_zc = zc;
    next_zo = zo;
    next_ref = ref_b;
    next_ifr = ifr;
    next_fail1 = fail1;
    next_txif = txif;
    next_zero = zero;
    next_ds = ds_data;
    next_err = 1'b0;
    next_fp = 1'b0;
    for (int i = 0; i < 3; i++) begin
      cn[i] = corr[i] + {6'h00, hit[i]}; // parallel match counts
      tn[i] = tc[i] + {5'h00, hit[i]};
    end
    acq_ok = (cn[0] >= `GFS_L3_NEED) || (cn[1] >= `GFS_L3_NEED) ||
             ((cn[2] >= `GFS_L3_NEED) && zero);
    mnt_ok = (cn[0] >= `GFS_MNT_NEED) || (cn[1] >= `GFS_MNT_NEED) ||
             ((cn[2] >= `GFS_MNT_NEED) && zero);
    if (!go_frame_n && fst != F_HUNT) begin
      next_fst = F_HUNT; // search for a one
      next_ifr = 1'b0;
      next_fail1 = 1'b0;
    end else if (stb) begin
      next_ds = rx_data_en ? d : 1'b1;
      next_pos = (pos == `GFS_FRAME_LEN - 7'd1) ? 7'h00 : pos + 7'd1;
      if (!(locked && pos == 7'h00)) begin
        next_zc = zc + 9'd1; // zero data detector
        next_zo = zo + {9'h000, d};
        if (zc == `GFS_ZD_LAST) begin
          next_zero = (zo + {9'h000, d}) < `GFS_ZD_MIN;
          next_zo = 10'h000;
        end
      end
      if (fst == F_HUNT) begin
        if (d) begin
          next_fst = F_L1; // first one is frame bit one
          next_pos = 7'd1;
          next_nfb = 7'd1;
          next_ref = 1'b0; // reference aligned to 1010
          next_corr = '0;
        end
      end else if (locked && pos == 7'h00) begin
        next_ref = ~ref_b;
        next_fp = 1'b1;
        next_err = (d != ref_b);
        next_nfb = k;
        next_corr = cn;
        next_tc = tn; // far end pattern detector
        next_tcnt = tcnt + 5'd1;
        if (tcnt == `GFS_TX_LAST) begin
          next_tc = '0;
          if (tn[0] >= `GFS_TX_NEED || tn[1] >= `GFS_TX_NEED) begin
            next_txif = 1'b1;
          end else if (tn[2] >= `GFS_TX_NEED && zero) begin
            next_txif = 1'b0;
          end
        end
        unique case (fst)
          F_L1: begin
            if (k == `GFS_L1_BIT) begin
              next_fst = d ? F_L2 : F_HUNT;
              next_corr = '0;
            end
          end
          F_L2: begin
            next_corr = corr;
            if (k == `GFS_L2_BIT_A || k == `GFS_L2_BIT_B ||
                k == `GFS_L2_BIT_C) begin
              next_corr[2] = cn[2];
            end
            if (k == `GFS_L2_BIT_C) begin
              next_fst = (cn[2] >= `GFS_L2_NEED) ? F_L3 : F_HUNT;
              next_corr = '0;
            end
          end
          F_L3: begin
            if (k == `GFS_L3_LAST) begin
              next_fst = acq_ok ? F_MAINT : F_HUNT;
              next_ifr = acq_ok;
              next_nfb = 7'h00;
              next_corr = '0;
            end
          end
          F_MAINT: begin
            if (k == `GFS_MNT_LEN) begin
              next_nfb = 7'h00;
              next_corr = '0;
              if (mnt_ok) begin
                next_ifr = 1'b1;
                next_fail1 = 1'b0;
              end else begin
                next_fail1 = 1'b1;
                if (fail1) next_ifr = 1'b0; // second miss
              end
            end
          end
          default: next_fst = F_HUNT;
        endcase
      end
    end
  end

  // framer registers; idle and out of frame after reset
  always_ff @(posedge mclk) begin
    if (reset) begin
      fst <= F_IDLE;
      pos <= 7'h00;
      nfb <= 7'h00;
      corr <= '0;
      tc <= '0;
      tcnt <= 5'h00;
      zc <= 9'h000;
      zo <= 10'h000;
      ref_b <= 1'b0;
      ifr <= 1'b0;
      fail1 <= 1'b0;
      txif <= 1'b0;
      zero <= 1'b0;
      ds_data <= 1'b1;
      err_pulse <= 1'b0;
      frame_pulse <= 1'b0;
      frame_ref <= 1'b0;
      rx_inframe <= 1'b0;
      tx_inframe <= 1'b0;
    end else if (ce) begin
      fst <= next_fst;
      pos <= next_pos;
      nfb <= next_nfb;
      corr <= next_corr;
      tc <= next_tc;
      tcnt <= next_tcnt;
      zc <= next_zc;
      zo <= next_zo;
      ref_b <= next_ref;
      ifr <= next_ifr;
      fail1 <= next_fail1;
      txif <= next_txif;
      zero <= next_zero;
      ds_data <= next_ds;
      err_pulse <= next_err;
      frame_pulse <= next_fp;
      frame_ref <= next_ref;
      rx_inframe <= next_ifr | ~sq_n; // squelch forces in frame
      tx_inframe <= next_txif;
    end
  end

  // -------------------------------------------------------------
  // link sequencer
  // -------------------------------------------------------------
  gfs_sstate_t sst, next_sst;
  logic [31:0] tmr, next_tmr, tout, next_tout;
  logic next_rxen, next_txen, next_pat, next_rsy, next_alarm_n;
  logic next_gon, seq_en;

  // next state of the sequencer and its control levels
  always_comb begin
    next_sst = sst;
    next_tmr = (tmr != 32'h0) ? tmr - 32'd1 : tmr;
    next_tout = (tout != 32'h0) ? tout - 32'd1 : tout;
    next_rxen = rx_data_en;
    next_txen = tx_data_en;
    next_pat = pattern_sel;
    next_rsy = link_encryptor_resync;
    next_alarm_n = frame_alarm_n;
    next_gon = (stb || !seq_en) ? 1'b1 : go_frame_n; // one bit
    unique case (sst)
      S_IDLE: begin
        if (!sq_n) begin
          next_rxen = 1'b1;
          next_txen = 1'b1;
          next_pat = 1'b1;
        end else if (seq_en && !rx_inframe) begin
          next_sst = S_DELAY;
          next_tmr = dly_on ? T_DELAY : 32'h0;
        end else if (seq_en && !tx_inframe) begin
          next_sst = S_ZHOLD;
          next_txen = 1'b0; // far end sends ones
          next_tout = T_RETRY;
        end
      end
      S_DELAY: begin
        if (rx_inframe) begin
          next_sst = S_IDLE;
        end else if (tmr == 32'h0) begin
          next_rxen = 1'b0;
          next_pat = 1'b0;
          next_txen = 1'b0;
          next_tout = T_TOUT;
          next_sst = S_CHECK;
        end
      end
      S_CHECK: begin
        if (fit && esync) begin
          next_rsy = 1'b1;
          next_tmr = T_PULSE - 32'd1;
          next_sst = S_PULSE;
        end else begin
          next_tmr = T_WAIT;
          next_sst = S_WAIT500;
        end
      end
      S_PULSE: begin
        if (tmr == 32'h0) begin
          next_rsy = 1'b0;
          next_tmr = T_WAIT;
          next_sst = S_WAIT500;
        end
      end
      S_WAIT500: if (tmr == 32'h0) next_sst = S_WAITSYNC;
      S_WAITSYNC: begin
        if (esync) begin
          next_gon = 1'b0;
          next_sst = S_WAITIF;
        end
      end
      S_WAITIF: begin
        if (rx_inframe) begin
          next_pat = 1'b1;
          next_rxen = 1'b1;
          next_sst = S_WAITTX;
        end
      end
      S_WAITTX: begin
        if (tx_inframe) begin
          next_txen = 1'b1;
          next_sst = S_IDLE;
        end
      end
      S_ZHOLD: begin
        if (link_encryptor_resync && tmr == 32'h0) next_rsy = 1'b0;
        if (!rx_inframe) begin
          next_sst = S_DELAY;
          next_tmr = dly_on ? T_DELAY : 32'h0;
        end else if (tx_inframe) begin
          next_txen = 1'b1; // 1010 back
          next_sst = S_IDLE;
        end else if (tout == 32'h0) begin
          next_tout = T_RETRY; // try again
          next_rsy = fit;
          next_tmr = T_PULSE - 32'd1;
        end
      end
    endcase
    if (sst != S_IDLE && sst != S_DELAY && sst != S_ZHOLD &&
        tout == 32'h0) begin
      next_sst = S_CHECK; // retry entry point
      next_tout = T_TOUT;
      next_rsy = 1'b0;
      next_gon = 1'b1;
      next_alarm_n = 1'b0;
    end else if (rx_inframe) begin
      next_alarm_n = 1'b1;
    end
  end

  // sequencer registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      sst <= S_IDLE;
      tmr <= 32'h0;
      tout <= 32'h0;
      rx_data_en <= 1'b0;
      tx_data_en <= 1'b0;
      pattern_sel <= 1'b0;
      link_encryptor_resync <= 1'b0;
      frame_alarm_n <= 1'b1;
      go_frame_n <= 1'b1;
    end else if (ce) begin
      sst <= next_sst;
      tmr <= next_tmr;
      tout <= next_tout;
      rx_data_en <= next_rxen;
      tx_data_en <= next_txen;
      pattern_sel <= next_pat;
      link_encryptor_resync <= next_rsy;
      frame_alarm_n <= next_alarm_n;
      go_frame_n <= next_gon;
    end
  end

  // -------------------------------------------------------------
  // avalon register slave
  // -------------------------------------------------------------
  logic [15:0] errcnt, next_errcnt;
  logic [31:0] next_rdata;
  logic next_wait, next_seq_en, req, acc, cap;
  gfs_stat_t st;

  assign req = avl_req.read | avl_req.write;
  assign cap = req & avl_waitrequest;
  assign acc = req & ~avl_waitrequest;
  always_comb begin
    st.alarm = ~frame_alarm_n;
    st.pattern_sel = pattern_sel;
    st.tx_data_en = tx_data_en;
    st.rx_data_en = rx_data_en;
    st.zero_data = zero;
    st.tx_inframe = tx_inframe;
    st.rx_inframe = rx_inframe;
    unique case (fst)
      F_L1: st.level = 3'd1;
      F_L2: st.level = 3'd2;
      F_L3: st.level = 3'd3;
      F_MAINT: st.level = 3'd4;
      default: st.level = 3'd0;
    endcase
  end

  // one wait state per access; error count clears on read
  always_comb begin
    next_wait = ~cap;
    next_rdata = avl_readdata;
    next_seq_en = seq_en;
    next_errcnt = (err_pulse && errcnt != 16'hFFFF) ?
                  errcnt + 16'd1 : errcnt;
    if (cap && avl_req.read) begin
      unique case (avl_req.address)
        `GFS_REG_CTRL: next_rdata = {31'h0, seq_en};
        `GFS_REG_STATUS: next_rdata = {22'h0, st};
        `GFS_REG_ERRCNT: begin
          next_rdata = {16'h0, errcnt};
          next_errcnt = {15'h0, err_pulse}; // new error wins
        end
        default: next_rdata = 32'h0;
      endcase
    end
    if (acc && avl_req.write && avl_req.byteenable[0] &&
        avl_req.address == `GFS_REG_CTRL) begin
      next_seq_en = avl_req.writedata[0];
    end
  end

  // bus registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      avl_waitrequest <= 1'b1;
      avl_readdata <= 32'h0;
      seq_en <= `GFS_CTRL_RST;
      errcnt <= 16'h0;
    end else if (ce) begin
      avl_waitrequest <= next_wait;
      avl_readdata <= next_rdata;
      seq_en <= next_seq_en;
      errcnt <= next_errcnt;
    end
  end
endmodule
`default_nettype wire

// ==== gfs_defines.svh ====
// gfs_defines.svh: offsets, field values and timing counts for the
// group frame sync controller.
// assumes a 250 MHz mclk and a group bit clock well below mclk/4.
//
// Notes on behaviour
// - a search command makes the framer hunt for a received one
// - after a one, emit a toggling frame reference and a frame-bit pulse
// - compare frame bits with ones, 0101, 1010; pulse and count errors
// - count matches for all three patterns in parallel
// - the first received one after search enters level one
// - level one: framing bit three must be one to advance
// - level two: two of bits five, six, nine must be one
// - level three: 30 of bits 10..41 correct declares in-frame
// - any level one to three failure restarts the hunt
// - free detector: under 171 ones per 512 data bits flags zero data
// - maintenance: 58 of 100 correct keeps in-frame
// - two failed 100-bit intervals in a row report out of frame
// - 32-bit detector sets or clears transmit-side-in-frame at 30 hits
// - low squelch forces in-frame, data enable and alternating pattern (the enables and pattern only while the sequencer is idle)
// - low receive enable forces downstream data to ones
// - out of frame: optional half second delay, then blank traffic
// - start 2.13 s timeout; resync the encryptor if it is fitted and in sync
// - after 500 us wait for encryptor sync, then issue search
// - in frame: alternating pattern, receive data, then transmit data
// - timeout retries and raises an alarm until in frame again
// - far end sends ones: zero transmit data, retry every 14 s
// - the search command is low for one bit clock period
// - the resync command is a 32 us high pulse
// - pattern select low sends ones, high sends alternating
`ifndef GFS_DEFINES_SVH
`define GFS_DEFINES_SVH

`define GFS_CLK_HZ 64'd250000000
`define GFS_MS2CYC(ms) ((64'(ms) * `GFS_CLK_HZ + 64'd999) / 64'd1000)
`define GFS_US2CYC(us) ((64'(us) * `GFS_CLK_HZ + 64'd999999) / 64'd1000000)

`define GFS_T_DELAY_MS 500
`define GFS_T_TOUT_MS 2130
`define GFS_T_RETRY_MS 14000
`define GFS_T_WAIT_US 500
`define GFS_T_PULSE_US 32

`define GFS_FRAME_LEN 7'd72
`define GFS_L1_BIT 7'd3
`define GFS_L2_BIT_A 7'd5
`define GFS_L2_BIT_B 7'd6
`define GFS_L2_BIT_C 7'd9
`define GFS_L2_NEED 7'd2
`define GFS_L3_LAST 7'd41
`define GFS_L3_NEED 7'd30
`define GFS_MNT_LEN 7'd100
`define GFS_MNT_NEED 7'd58
`define GFS_TX_LAST 5'h1F
`define GFS_TX_NEED 6'd30
`define GFS_ZD_LAST 9'h1FF
`define GFS_ZD_MIN 10'd171

`define GFS_REG_CTRL 4'h0
`define GFS_REG_STATUS 4'h4
`define GFS_REG_ERRCNT 4'h8
`define GFS_CTRL_RST 1'b1

`endif

// ==== gfs_pkg.sv ====
// gfs_pkg.sv: types shared by the group frame sync controller.
// assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package gfs_pkg;
  typedef enum logic [2:0] {
    F_IDLE, F_HUNT, F_L1, F_L2, F_L3, F_MAINT
  } gfs_fstate_t;
  typedef enum logic [3:0] {
    S_IDLE, S_DELAY, S_CHECK, S_PULSE, S_WAIT500, S_WAITSYNC,
    S_WAITIF, S_WAITTX, S_ZHOLD
  } gfs_sstate_t;
  typedef struct packed {
    logic read;
    logic write;
    logic [3:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } gfs_avl_req_t;
  typedef struct packed {
    logic alarm;
    logic pattern_sel;
    logic tx_data_en;
    logic rx_data_en;
    logic zero_data;
    logic tx_inframe;
    logic rx_inframe;
    logic [2:0] level;
  } gfs_stat_t;
endpackage
`default_nettype wire

// ==== gfs_top_asserts.sv ====
// gfs_top_asserts.sv: concurrent checks on the controller's pins.
// assumes gfs_top is compiled first; bound to every gfs_top instance.
`default_nettype none
module gfs_top_asserts #(
  parameter logic [31:0] T_PULSE = 32'h8 // resync pulse width in mclk
) (
  input wire logic mclk, // system clock
  input wire logic reset, // sync reset, high
  input wire logic squelch_n_pin, // low forces in frame
  input wire logic ds_data, // downstream data
  input wire logic err_pulse, // frame bit error
  input wire logic go_frame_n, // search command
  input wire logic rx_inframe, // receive side in frame
  input wire logic rx_data_en, // 0 = downstream ones
  input wire logic tx_data_en, // 0 = transmit zeros
  input wire logic pattern_sel, // 0 = ones, 1 = alternating
  input wire logic link_encryptor_resync, // resync pulse
  input wire logic frame_alarm_n // 0 = frame alarm
);
  logic [4:0] ren_lo, next_ren_lo;
  logic [3:0] sq_lo, next_sq_lo;
  logic [31:0] pw, next_pw;
  // --------------------
  // helper run lengths
  // --------------------
  // saturating low-time counts and the resync pulse width
  always_comb begin
    next_ren_lo = rx_data_en ? 5'h00 : ren_lo + {4'h0, ren_lo != 5'h1F};
    next_sq_lo = squelch_n_pin ? 4'h0 : sq_lo + {3'h0, sq_lo != 4'hF};
    next_pw = link_encryptor_resync ? pw + 32'h1 : 32'h0;
  end
  // registers the run lengths, cleared by reset
  always_ff @(posedge mclk) begin
    if (reset) begin
      ren_lo <= 5'h00;
      sq_lo <= 4'h0;
      pw <= 32'h0;
    end else begin
      ren_lo <= next_ren_lo;
      sq_lo <= next_sq_lo;
      pw <= next_pw;
    end
  end
  // --------------------
  // properties
  // --------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  sequence s_rx_on;
    pattern_sel && rx_data_en;
  endsequence
  sequence s_blanked;
    !rx_data_en && !tx_data_en;
  endsequence
  property p_search_pulse;
    $fell(go_frame_n) |-> ##[1:20] go_frame_n;
  endproperty
  a_search_pulse: assert property (p_search_pulse)
    else $error("search command held low too long");
  property p_resync_width;
    $fell(link_encryptor_resync) |-> pw == T_PULSE;
  endproperty
  a_resync_width: assert property (p_resync_width)
    else $error("resync pulse has the wrong width");
  property p_resync_gate;
    $rose(link_encryptor_resync) |-> !tx_data_en;
  endproperty
  a_resync_gate: assert property (p_resync_gate)
    else $error("resync sent while transmit data enabled");
  property p_ds_forced;
    ren_lo >= 5'h14 |-> ds_data;
  endproperty
  a_ds_forced: assert property (p_ds_forced)
    else $error("downstream data not forced to one");
  property p_squelch;
    sq_lo >= 4'h8 |-> rx_inframe && pattern_sel && rx_data_en;
  endproperty
  a_squelch: assert property (p_squelch)
    else $error("low squelch did not force in frame");
  property p_alarm_clear;
    rx_inframe [*3] |-> frame_alarm_n;
  endproperty
  a_alarm_clear: assert property (p_alarm_clear)
    else $error("alarm still set while in frame");
  property p_err_single;
    err_pulse |=> !err_pulse;
  endproperty
  a_err_single: assert property (p_err_single)
    else $error("error pulse longer than one cycle");
  property p_inframe_on;
    $rose(rx_inframe) |-> ##[1:8] s_rx_on;
  endproperty
  a_inframe_on: assert property (p_inframe_on)
    else $error("in frame without alternating pattern");
  property p_tx_order;
    $rose(tx_data_en) |-> s_rx_on;
  endproperty
  a_tx_order: assert property (p_tx_order)
    else $error("transmit enabled before receive side");
  property p_blank;
    $fell(pattern_sel) |-> s_blanked;
  endproperty
  a_blank: assert property (p_blank)
    else $error("ones pattern without blanked traffic");
endmodule

bind gfs_top gfs_top_asserts #(.T_PULSE(T_PULSE)) u_asserts (
  .mclk(mclk),
  .reset(reset),
  .squelch_n_pin(squelch_n_pin),
  .ds_data(ds_data),
  .err_pulse(err_pulse),
  .go_frame_n(go_frame_n),
  .rx_inframe(rx_inframe),
  .rx_data_en(rx_data_en),
  .tx_data_en(tx_data_en),
  .pattern_sel(pattern_sel),
  .link_encryptor_resync(link_encryptor_resync),
  .frame_alarm_n(frame_alarm_n)
);
`default_nettype wire

// ==== gfs_far_model.sv ====
// gfs_far_model.sv: far-end group multiplexer and link encryptor.
// assumes a 250 MHz mclk; makes its own free-running 48 ns bit clock.
`default_nettype none
module gfs_far_model (
  input wire logic mclk, // system clock
  input wire logic alt, // 1 = alternating frame bits, 0 = all ones
  input wire logic zero, // 1 = channel data forced to zeros
  input wire logic rnd, // random channel bit
  input wire logic resync, // resync command from the controller
  output logic gclk, // group bit clock
  output logic rx_data, // group data toward the controller
  output logic sync // 1 = encryptor in sync
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [6:0] pos = 7'h00;
  logic phase = 1'b1;
  logic rs_q = 1'b0;
  int wait_cnt = 0;
  // free-running clock, phase unrelated to mclk
  initial begin
    gclk = 1'b0;
    rx_data = 1'b0;
    sync = 1'b1;
    #7;
    forever #24 gclk = ~gclk;
  end
  // 72-bit frame, frame bit first; launched on the fall, stable at rise
  always @(negedge gclk) begin
    rx_data <= (pos == 7'h00) ? (alt ? phase : 1'b1) : (~zero & rnd);
    if (pos == 7'h00) begin
      phase <= ~phase;
    end
    pos <= (pos == 7'h47) ? 7'h00 : pos + 7'h01;
  end
  // encryptor loses sync on resync and regains it 30 cycles later
  always @(posedge mclk) begin
    rs_q <= resync;
    if (resync && !rs_q) begin
      sync <= 1'b0;
      wait_cnt <= 30;
    end else if (wait_cnt > 1) begin
      wait_cnt <= wait_cnt - 1;
    end else if (wait_cnt == 1) begin
      sync <= 1'b1;
      wait_cnt <= 0;
    end
  end
endmodule
`default_nettype wire

// ==== gfs_top_bench.sv ====
// gfs_top_bench.sv: self-checking bench for the frame sync controller.
// assumes gfs_pkg, gfs_top, the checker and gfs_far_model compiled.
`default_nettype none
module gfs_top_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import gfs_pkg::*;
  localparam int FRAME = 864; // mclk cycles per 72-bit frame
  logic mclk, reset, ce, squelch_n, rnd, alt, zero, seen_rs = 1'b0;
  gfs_avl_req_t req;
  logic [31:0] rdata, rd;
  logic wreq, ds_data, err_pulse, frame_ref, frame_pulse, go_frame_n;
  logic rx_inframe, tx_inframe, rx_data_en, tx_data_en, pattern_sel;
  logic resync, alarm_n, gclk, rxd, sync, dly_sw, fitted_n;
  int err_total, checks, n, cyc = 0;
  integer seed;
  // --------------------
  // tasks and functions
  // --------------------
  // expected status bits: level, in frame, rx enable, pattern, alarm
  function automatic logic [31:0] stat(logic [2:0] lv, logic rif,
                                      logic ren, logic ps, logic al);
    return {22'h0, al, ps, 1'b0, ren, 2'h0, rif, lv};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s exp=%h seen=%h", nm, exp, seen);
    end
  endtask
  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] wd, output logic [31:0] q);
    req.read <= ~wr;
    req.write <= wr;
    req.address <= a;
    req.byteenable <= 4'hF;
    req.writedata <= wd;
    do begin
      @(posedge mclk);
    end while (wreq !== 1'b0);
    q = rdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic finish_test;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // --------------------
  // structure
  // --------------------
  gfs_top #(.T_DELAY(32'h28), .T_TOUT(32'h30D40), .T_RETRY(32'h61A80),
    .T_WAIT(32'h14), .T_PULSE(32'h8)) DUT (
    .mclk(mclk), .reset(reset), .ce(ce), .avl_req(req),
    .avl_readdata(rdata), .avl_waitrequest(wreq), .gclk_pin(gclk),
    .rx_data_pin(rxd), .squelch_n_pin(squelch_n), .delay_sw_pin(dly_sw),
    .link_encryptor_fitted_n(fitted_n), .link_encryptor_sync(sync),
    .ds_data(ds_data), .err_pulse(err_pulse), .frame_ref(frame_ref),
    .frame_pulse(frame_pulse), .go_frame_n(go_frame_n),
    .rx_inframe(rx_inframe), .tx_inframe(tx_inframe),
    .rx_data_en(rx_data_en), .tx_data_en(tx_data_en),
    .pattern_sel(pattern_sel), .link_encryptor_resync(resync),
    .frame_alarm_n(alarm_n));
  gfs_far_model u_far (.mclk(mclk), .alt(alt), .zero(zero), .rnd(rnd),
    .resync(resync), .gclk(gclk), .rx_data(rxd), .sync(sync));
  // 250 MHz system clock
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // random channel data, resync monitor and run timeout
  always @(posedge mclk) begin
    rnd <= 1'($random(seed));
    if (resync === 1'b1) seen_rs <= 1'b1;
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_total++;
      finish_test;
    end
  end
  // --------------------
  // scenarios
  // --------------------
  initial begin
    seed = 73584;
    err_total = 0;
    checks = 0;
    reset = 1'b1;
    ce = 1'b1;
    squelch_n = 1'b0;
    alt = 1'b1;
    zero = 1'b0;
    dly_sw = 1'b1;
    fitted_n = 1'b0;
    req = '0;
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    repeat (8) @(posedge mclk);
    bus(1'b0, 4'h0, 32'h0, rd);
    chk("ctrl", rd, 32'h1);
    bus(1'b1, 4'hC, 32'hFFFFFFFF, rd);
    bus(1'b0, 4'hC, 32'h0, rd);
    chk("unmapped", rd, 32'h0);
    bus(1'b1, 4'h0, 32'h1, rd);
    bus(1'b0, 4'h4, 32'h0, rd);
    chk("status_sq", rd & 32'h34F,
        stat(3'h0, 1'b1, 1'b1, 1'b1, 1'b0));
    chk("search_idle", go_frame_n, 32'h1);
    // squelch released: delay, blank, resync, search, acquire
    squelch_n <= 1'b1;
    for (n = 0; n < 400 && pattern_sel !== 1'b0; n++) @(posedge mclk);
    chk("delay", 32'(n >= 40), 32'h1);
    chk("blank_rx", rx_data_en, 32'h0);
    chk("blank_tx", tx_data_en, 32'h0);
    chk("lost", rx_inframe, 32'h0);
    zero <= 1'b1;
    for (n = 0; n < 400 && go_frame_n !== 1'b0; n++) @(posedge mclk);
    chk("resync_seen", seen_rs, 32'h1);
    chk("sync_first", sync, 32'h1);
    for (n = 0; n < 40000 && rx_inframe !== 1'b1; n++) @(posedge mclk);
    chk("acquired", rx_inframe, 32'h1);
    chk("acq_time",
        32'(n >= 40 * FRAME - 700 && n <= 42 * FRAME), 32'h1);
    repeat (8) @(posedge mclk);
    chk("alt_sel", pattern_sel, 32'h1);
    chk("rx_en", rx_data_en, 32'h1);
    bus(1'b0, 4'h4, 32'h0, rd);
    chk("level", rd[2:0], 32'h4);
    chk("zero_flag", rd[5], 32'h1);
    bus(1'b0, 4'h8, 32'h0, rd);
    chk("err_none", rd, 32'h0);
    // far end enables data; wait for transmit enable
    zero <= 1'b0;
    for (n = 0; n < 60000 && tx_data_en !== 1'b1; n++) @(posedge mclk);
    chk("tx_en", tx_data_en, 32'h1);
    chk("far_in", tx_inframe, 32'h1);
    chk("no_alarm", alarm_n, 32'h1);
    // ones pattern: every second frame bit misses the 1010 reference
    bus(1'b0, 4'h8, 32'h0, rd);
    alt <= 1'b0;
    repeat (10 * FRAME) @(posedge mclk);
    bus(1'b0, 4'h8, 32'h0, rd);
    chk("err_ones", 32'(rd >= 32'h4 && rd <= 32'h6), 32'h1);
    chk("maint", rx_inframe, 32'h1);
    for (n = 0; n < 2 * FRAME && frame_pulse !== 1'b1; n++) @(posedge mclk);
    chk("fr_pulse", frame_pulse, 32'h1);
    finish_test;
  end
endmodule
`default_nettype wire
